/* rtl/nv_memory_program_control.sv */
// Program control for on-chip EPROM and EEPROM with an AHB-Lite register slave.
// Assumes an external cell array on the nv ports and a byte host link for the loader.
`timescale 1ns/1ps
`default_nettype none
module nv_memory_program_control import nv_prog_pkg::*; #(
	parameter int ADDR_WIDTH = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic testMode,
	output logic [ADDR_WIDTH-1:0] nvAddr,
	output logic [7:0] nvWrData,
	input wire logic [7:0] nvRdData,
	output logic nvLatched,
	output logic ignoreAddr5,
	output logic columnExclude,
	output logic rowExclude,
	output logic epromProgramVoltageOn,
	output logic eepromProgramVoltageOn,
	output logic eepromErase,
	output logic eepromRowSelect,
	output logic eepromByteSelect,
	input wire logic hostTxReady,
	output logic hostTxValid,
	output logic [7:0] hostTxData,
	input wire logic hostRxValid,
	input wire logic [7:0] hostRxData,
	output logic resetRequest
);
	logic rstMeta, rstN;
	logic [4:0] tickCntQ;
	logic tick;
	logic dphWriteQ;
	logic [9:0] dphIdxQ;
	logic [7:0] epromCtlQ, eepromCtlQ;
	logic mbeQ;
	logic [ADDR_WIDTH-1:0] addrQ;
	logic [7:0] dataQ;
	logic latchedQ;
	logic [15:0] bootDelayQ, bootStartQ, bootCountQ;
	logic bootStart, bootLoad, bootHv, bootBusy;
	logic [15:0] bootAddr;
	logic [7:0] bootData;
	logic hvAny, eepromLatch, epromLatch, addrPhase, wrCtlEp, wrCtlEe, wrAddr, wrData;
	logic [31:0] rdNext;

	// ------------------------------------------------------------
	// Reset release and microsecond tick
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			tickCntQ <= 5'd0;
		end else if (tickCntQ == 5'(TICK_CYCLES - 1)) begin
			tickCntQ <= 5'd0;
		end else begin
			tickCntQ <= tickCntQ + 5'd1;
		end
	end
	assign tick = (tickCntQ == 5'(TICK_CYCLES - 1));

	// ------------------------------------------------------------
	// Bus slave: zero wait states, read data fetched in address phase
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrPhase = hsel && htrans[1] && hready;

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			dphWriteQ <= 1'b0;
			dphIdxQ <= 10'h000;
		end else if (hready) begin
			dphWriteQ <= addrPhase && hwrite && haddr[31:12] == 20'h00000 && haddr[1:0] == 2'b00;
			dphIdxQ <= haddr[11:2];
		end
	end

	assign wrCtlEp = dphWriteQ && dphIdxQ == EPROM_CTL_IDX;
	assign wrCtlEe = dphWriteQ && dphIdxQ == EEPROM_CTL_IDX;
	assign wrAddr = dphWriteQ && dphIdxQ == ARRAY_ADDR_IDX;
	assign wrData = dphWriteQ && dphIdxQ == ARRAY_DATA_IDX;
	assign bootStart = dphWriteQ && dphIdxQ == BOOT_COUNT_IDX;

	// Unmapped or misaligned reads return zero
	always_comb begin
		rdNext = 32'h0000_0000;
		if (haddr[31:12] == 20'h00000 && haddr[1:0] == 2'b00) begin
			case (haddr[11:2])
				EPROM_CTL_IDX: rdNext = {24'h00_0000, epromCtlQ};
				EEPROM_CTL_IDX: rdNext = {24'h00_0000, eepromCtlQ};
				ARRAY_ADDR_IDX: rdNext = 32'(addrQ);
				ARRAY_DATA_IDX: rdNext = hvAny ? 32'h0000_0000 : {24'h00_0000, nvRdData};
				STATUS_IDX: rdNext = {27'h000_0000, bootBusy, latchedQ, eepromProgramVoltageOn,
					epromProgramVoltageOn, hvAny};
				BOOT_DELAY_IDX: rdNext = {16'h0000, bootDelayQ};
				BOOT_START_IDX: rdNext = {16'h0000, bootStartQ};
				BOOT_COUNT_IDX: rdNext = {16'h0000, bootCountQ};
				TEST_IDX: rdNext = {31'h0000_0000, mbeQ};
				default: rdNext = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdNext;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// EPROM control, masked to its four bits
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			epromCtlQ <= EPROM_CTL_RESET;
		end else if (wrCtlEp) begin
			epromCtlQ <= hwdata[7:0] & EPROM_CTL_MASK;
		end
	end

	// Clearing the word drops the voltage
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			eepromCtlQ <= EEPROM_CTL_RESET;
		end else if (wrCtlEe) begin
			eepromCtlQ <= hwdata[7:0] & EEPROM_CTL_MASK;
		end
	end

	// Multi-byte enable only writable in test mode
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			mbeQ <= 1'b0;
		end else if (!testMode) begin
			mbeQ <= 1'b0;
		end else if (dphWriteQ && dphIdxQ == TEST_IDX) begin
			mbeQ <= hwdata[TEST_MBE];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			bootDelayQ <= BOOT_DELAY_RESET;
			bootStartQ <= BOOT_START_RESET;
			bootCountQ <= BOOT_COUNT_RESET;
		end else begin
			if (dphWriteQ && dphIdxQ == BOOT_DELAY_IDX) bootDelayQ <= hwdata[15:0];
			if (dphWriteQ && dphIdxQ == BOOT_START_IDX) bootStartQ <= hwdata[15:0];
			if (bootStart) bootCountQ <= hwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// Address and data latches
	// ------------------------------------------------------------
	assign epromLatch = epromCtlQ[EP_LATCH] || bootBusy;
	assign eepromLatch = eepromCtlQ[EE_LATCH];
	assign hvAny = epromProgramVoltageOn || eepromProgramVoltageOn;

	// Array address frozen while voltage is on
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			addrQ <= '0;
		end else if (bootLoad) begin
			addrQ <= bootAddr[ADDR_WIDTH-1:0];
		end else if (wrAddr && !hvAny && !bootBusy) begin
			addrQ <= hwdata[ADDR_WIDTH-1:0];
		end
	end

	// Writes blocked while program voltage on or loader busy
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			dataQ <= 8'h00;
			latchedQ <= 1'b0;
		end else if (bootLoad) begin
			dataQ <= bootData;
			latchedQ <= 1'b1;
		end else if (!epromLatch && !eepromLatch) begin
			latchedQ <= 1'b0;
		end else if (wrData && !hvAny && !bootBusy) begin
			dataQ <= hwdata[7:0];
			latchedQ <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Array outputs
	// ------------------------------------------------------------
	// Address bit five dropped for multi-byte
	always_comb begin
		nvAddr = addrQ;
		if (mbeQ) nvAddr[ADDR_BIT5] = 1'b0;
	end
	assign ignoreAddr5 = mbeQ;
	assign nvWrData = dataQ;
	assign nvLatched = latchedQ;
	assign columnExclude = epromCtlQ[EP_COLEX];
	assign rowExclude = epromCtlQ[EP_ROWEX];
	assign epromProgramVoltageOn = (epromCtlQ[EP_PGM] && epromCtlQ[EP_LATCH]) || bootHv;
	assign eepromProgramVoltageOn = eepromCtlQ[EE_PGM] && eepromCtlQ[EE_LATCH];
	assign eepromErase = eepromCtlQ[EE_ERASE];
	assign eepromRowSelect = eepromCtlQ[EE_ROW];
	assign eepromByteSelect = eepromCtlQ[EE_BYTE];

	// ------------------------------------------------------------
	// Bootstrap loader
	// ------------------------------------------------------------
	boot_loader loader (
		.mclk(mclk),
		.rstN(rstN),
		.start(bootStart),
		.tick(tick),
		.delayUs(bootDelayQ),
		.startAddr(bootStartQ),
		.byteCount(hwdata[15:0]),
		.txReady(hostTxReady),
		.txValid(hostTxValid),
		.txData(hostTxData),
		.rxValid(hostRxValid),
		.rxData(hostRxData),
		.rdData(nvRdData),
		.load(bootLoad),
		.loadAddr(bootAddr),
		.loadData(bootData),
		.hvOn(bootHv),
		.busy(bootBusy),
		.resetReq(resetRequest)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_block_write: assert property (@(posedge mclk) disable iff (!rstN)
		(eepromProgramVoltageOn && wrData && !bootLoad) |=> (dataQ == $past(dataQ)))
		else $error("array data changed while voltage on");
	a_hide_read: assert property (@(posedge mclk) disable iff (!rstN)
		(addrPhase && !hwrite && hvAny && haddr == {20'h00000, ARRAY_DATA_IDX, 2'b00}) |=> hrdata == 32'h0000_0000)
		else $error("array data visible while voltage on");
	a_ctl_mask: assert property (@(posedge mclk) disable iff (!rstN)
		wrCtlEp |=> (epromCtlQ == ($past(hwdata[7:0]) & 8'h39)))
		else $error("eprom control write not stored");
	a_mbe_addr: assert property (@(posedge mclk) disable iff (!rstN)
		mbeQ |-> (!nvAddr[5] && testMode) or (!testMode ##1 !mbeQ))
		else $error("multi-byte address bit five not dropped");
	a_latch_byte: assert property (@(posedge mclk) disable iff (!rstN)
		(wrData && epromCtlQ[EP_LATCH] && !hvAny && !bootBusy) |=> (latchedQ && nvWrData == $past(hwdata[7:0])))
		else $error("eprom byte not latched");
endmodule
`default_nettype wire

/* pkg/nv_prog_pkg.sv */
// Constants, register map and state codes for the nonvolatile program control block.
// Assumes a 25 MHz processor clock and word-aligned AHB-Lite register access.
package nv_prog_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [9:0] EPROM_CTL_IDX = 10'h02B;
	localparam logic [9:0] EEPROM_CTL_IDX = 10'h03B;
	localparam logic [9:0] ARRAY_ADDR_IDX = 10'h040;
	localparam logic [9:0] ARRAY_DATA_IDX = 10'h041;
	localparam logic [9:0] STATUS_IDX = 10'h042;
	localparam logic [9:0] BOOT_DELAY_IDX = 10'h043;
	localparam logic [9:0] BOOT_START_IDX = 10'h044;
	localparam logic [9:0] BOOT_COUNT_IDX = 10'h045;
	localparam logic [9:0] TEST_IDX = 10'h046;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int EP_LATCH = 5;
	localparam int EP_COLEX = 4;
	localparam int EP_ROWEX = 3;
	localparam int EP_PGM = 0;
	localparam int EE_BYTE = 4;
	localparam int EE_ROW = 3;
	localparam int EE_ERASE = 2;
	localparam int EE_LATCH = 1;
	localparam int EE_PGM = 0;
	localparam int TEST_MBE = 0;
	localparam int ADDR_BIT5 = 5;
	localparam logic [7:0] EPROM_CTL_MASK = 8'h39;
	localparam logic [7:0] EEPROM_CTL_MASK = 8'h1F;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] EPROM_CTL_RESET = 8'h00;
	localparam logic [7:0] EEPROM_CTL_RESET = 8'h00;
	localparam logic [15:0] BOOT_START_RESET = 16'h8000;
	localparam logic [15:0] BOOT_DELAY_RESET = 16'h03E8;
	localparam logic [15:0] BOOT_COUNT_RESET = 16'h0001;
	localparam logic [7:0] BOOT_READY_CODE = 8'hFF;
	// ------------------------------------------------------------
	// Loader states
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		BOOT_IDLE = 7'b000_0001,
		BOOT_SEND_READY = 7'b000_0010,
		BOOT_WAIT_BYTE = 7'b000_0100,
		BOOT_LATCH = 7'b000_1000,
		BOOT_BURN = 7'b001_0000,
		BOOT_VERIFY = 7'b010_0000,
		BOOT_FINISH = 7'b100_0000
	} boot_state_type;
endpackage

/* rtl/boot_loader.sv */
// Bootstrap loader: takes bytes from a host link and burns them into EPROM.
// Assumes a one-cycle microsecond tick and array read data valid once voltage is off.
`timescale 1ns/1ps
`default_nettype none
module boot_loader import nv_prog_pkg::*; (
	input wire logic mclk,
	input wire logic rstN,
	input wire logic start,
	input wire logic tick,
	input wire logic [15:0] delayUs,
	input wire logic [15:0] startAddr,
	input wire logic [15:0] byteCount,
	input wire logic txReady,
	output logic txValid,
	output logic [7:0] txData,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic [7:0] rdData,
	output logic load,
	output logic [15:0] loadAddr,
	output logic [7:0] loadData,
	output logic hvOn,
	output logic busy,
	output logic resetReq
);
	boot_state_type stateQ;
	logic [15:0] addrQ;
	logic [15:0] leftQ;
	logic [15:0] waitQ;
	logic echoQ;

	assign busy = (stateQ != BOOT_IDLE);
	assign hvOn = (stateQ == BOOT_BURN);
	assign txValid = (stateQ == BOOT_SEND_READY) || (stateQ == BOOT_VERIFY && echoQ);
	assign load = (stateQ == BOOT_LATCH);
	assign loadAddr = addrQ;

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			stateQ <= BOOT_IDLE;
		end else begin
			case (stateQ)
				BOOT_IDLE: if (start) stateQ <= BOOT_SEND_READY;
				BOOT_SEND_READY: if (txReady) stateQ <= BOOT_WAIT_BYTE;
				BOOT_WAIT_BYTE: if (rxValid) stateQ <= BOOT_LATCH;
				BOOT_LATCH: stateQ <= BOOT_BURN;
				BOOT_BURN: if (waitQ >= delayUs) stateQ <= BOOT_VERIFY;
				BOOT_VERIFY: if (echoQ && txReady) stateQ <= (leftQ <= 16'h0001) ? BOOT_FINISH : BOOT_WAIT_BYTE;
				BOOT_FINISH: stateQ <= BOOT_IDLE;
				default: stateQ <= BOOT_IDLE;
			endcase
		end
	end

	assign resetReq = (stateQ == BOOT_FINISH);

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			addrQ <= 16'h0000;
			leftQ <= 16'h0000;
		end else if (stateQ == BOOT_IDLE && start) begin
			addrQ <= startAddr;
			leftQ <= byteCount;
		end else if (stateQ == BOOT_VERIFY && echoQ && txReady) begin
			addrQ <= addrQ + 16'h0001;
			leftQ <= leftQ - 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			waitQ <= 16'h0000;
		end else if (stateQ != BOOT_BURN) begin
			waitQ <= 16'h0000;
		end else if (tick) begin
			waitQ <= waitQ + 16'h0001;
		end
	end

	// Echo waits one cycle: reads under voltage are invalid
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			echoQ <= 1'b0;
		end else begin
			echoQ <= (stateQ == BOOT_VERIFY);
		end
	end

	// Received byte held for burn; echo byte read back from array
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			loadData <= 8'h00;
			txData <= 8'h00;
		end else begin
			if (stateQ == BOOT_WAIT_BYTE && rxValid) begin
				loadData <= rxData;
			end
			if (stateQ == BOOT_IDLE) begin
				txData <= BOOT_READY_CODE;
			end else if (stateQ == BOOT_VERIFY && !echoQ) begin
				txData <= rdData;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_ready_first: assert property (@(posedge mclk) disable iff (!rstN)
		(stateQ == BOOT_IDLE && start) |=> (txValid && txData == 8'hFF))
		else $error("loader did not offer ready code first");
	a_reset_last: assert property (@(posedge mclk) disable iff (!rstN)
		(stateQ == BOOT_VERIFY && echoQ && txReady && leftQ <= 16'h0001) |=> resetReq ##1 !busy)
		else $error("loader did not request reset after last byte");
	a_load_addr: assert property (@(posedge mclk) disable iff (!rstN)
		(stateQ == BOOT_IDLE && start) |=> (loadAddr == $past(startAddr)))
		else $error("loader start address not taken");
endmodule
`default_nettype wire

/* verification/host_link_model.sv */
// Partner model: programming host on the byte link, plus the cell array.
// Assumes the block's clock; the bench queues host bytes before the loader runs.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	input wire logic mclk,
	input wire logic slowReady,
	input wire logic hostTxValid,
	input wire logic [7:0] hostTxData,
	output logic hostTxReady,
	output logic hostRxValid,
	output logic [7:0] hostRxData,
	input wire logic [15:0] nvAddr,
	input wire logic [7:0] nvWrData,
	input wire logic ignoreAddr5,
	input wire logic hvOn,
	output logic [7:0] nvRdData
);
	logic [7:0] mem [0:65535];
	logic [7:0] sendQueue [$];
	logic [7:0] echoes [$];
	logic started;
	logic [7:0] junk;
	int stall;
	initial begin
		hostTxReady = 1'b0;
		hostRxValid = 1'b0;
		hostRxData = 8'hA5;
		started = 1'b0;
		junk = 8'h5A;
		stall = 0;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'hFF;
		end
	end
	always @(posedge mclk) begin
		hostRxValid <= 1'b0;
		hostRxData <= ~hostRxData;
		junk <= ~junk;
		hostTxReady <= hostTxValid && !hostTxReady && (stall >= (slowReady ? 3 : 0));
		stall <= (hostTxValid && !hostTxReady) ? stall + 1 : 0;
		if (hostTxValid && hostTxReady) begin
			if (!started && hostTxData == 8'hFF) begin
				started <= 1'b1;
			end else begin
				echoes.push_back(hostTxData);
			end
			if (sendQueue.size() > 0) begin
				hostRxValid <= 1'b1;
				hostRxData <= sendQueue.pop_front();
			end
		end
	end
	always @(posedge mclk) begin
		if (hvOn) begin
			mem[nvAddr] <= nvWrData;
			if (ignoreAddr5) begin
				mem[nvAddr | 16'h0020] <= nvWrData;
			end
		end
	end
	// Reads under high voltage are garbage
	assign nvRdData = hvOn ? junk : mem[nvAddr];
endmodule
`default_nettype wire

/* verification/nv_memory_program_control_tb.sv */
// Self-checking bench: AHB-Lite register tasks, EPROM/EEPROM flows, bootstrap loader.
// Assumes the host_link_model partner and the package constants of the block.
`timescale 1ns/1ps
`default_nettype none
module nv_memory_program_control_tb;
	import nv_prog_pkg::*;
	logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, testMode, slowReady, resetRequest;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [15:0] nvAddr;
	logic [7:0] nvWrData, nvRdData, hostTxData, hostRxData;
	logic nvLatched, ignoreAddr5, columnExclude, rowExclude, epromProgramVoltageOn, eepromProgramVoltageOn;
	logic eepromErase, eepromRowSelect, eepromByteSelect, hostTxReady, hostTxValid, hostRxValid;
	int numErrors = 0;
	int comparisons = 0;
	int resetPulses = 0;
	int burnCycles = 0;
	nv_memory_program_control #(.ADDR_WIDTH(16)) i_nv_memory_program_control (.mclk(mclk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .testMode(testMode),
		.nvAddr(nvAddr), .nvWrData(nvWrData), .nvRdData(nvRdData), .nvLatched(nvLatched),
		.ignoreAddr5(ignoreAddr5), .columnExclude(columnExclude), .rowExclude(rowExclude),
		.epromProgramVoltageOn(epromProgramVoltageOn), .eepromProgramVoltageOn(eepromProgramVoltageOn),
		.eepromErase(eepromErase), .eepromRowSelect(eepromRowSelect), .eepromByteSelect(eepromByteSelect),
		.hostTxReady(hostTxReady), .hostTxValid(hostTxValid), .hostTxData(hostTxData),
		.hostRxValid(hostRxValid), .hostRxData(hostRxData), .resetRequest(resetRequest));
	host_link_model i_host_link_model (.mclk(mclk), .slowReady(slowReady), .hostTxValid(hostTxValid),
		.hostTxData(hostTxData), .hostTxReady(hostTxReady), .hostRxValid(hostRxValid),
		.hostRxData(hostRxData), .nvAddr(nvAddr), .nvWrData(nvWrData), .ignoreAddr5(ignoreAddr5),
		.hvOn(epromProgramVoltageOn | eepromProgramVoltageOn), .nvRdData(nvRdData));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (resetRequest === 1'b1) resetPulses++;
		if (epromProgramVoltageOn === 1'b1) burnCycles++;
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Waits as long as the slave stalls; only the watchdog ends a hang
	task automatic busWait();
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask
	// Address phase held until hready, then data phase until hready again
	task automatic busOp(input logic [9:0] idx, input logic wr, input logic [31:0] wdata, output logic [31:0] rdata);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {20'h0_0000, idx, 2'b00};
		busWait();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wr ? wdata : 32'h0000_0000;
		busWait();
		rdata = hrdata;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		logic [31:0] unused;
		busOp(idx, 1'b1, d, unused);
	endtask
	task automatic expectReg(input string what, input logic [9:0] idx, input logic [31:0] exp);
		busOp(idx, 1'b0, 32'h0000_0000, rd);
		check(what, rd, exp);
	endtask
	task automatic results();
		$display("Summary: %0d comparisons, %0d errors", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		numErrors++;
		results();
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		testMode = 1'b0;
		slowReady = 1'b0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		expectReg("eprom ctl reset", EPROM_CTL_IDX, 32'h0000_0000);
		expectReg("boot start reset", BOOT_START_IDX, 32'h0000_8000);
		expectReg("unmapped", 10'h3FF, 32'h0000_0000);
		wr(EPROM_CTL_IDX, 32'hFFFF_FFFE);
		expectReg("eprom ctl bits", EPROM_CTL_IDX, 32'h0000_0038);
		check("excludes", {columnExclude, rowExclude, epromProgramVoltageOn}, 32'h6);
		// EPROM byte: latch, load, burn, clear, verify
		wr(EPROM_CTL_IDX, 32'h0000_0020);
		wr(ARRAY_ADDR_IDX, 32'h0000_1234);
		wr(ARRAY_DATA_IDX, 32'h0000_00A5);
		@(negedge mclk);
		check("latched", {nvAddr, nvWrData, 7'h00, nvLatched}, 32'h1234_A501);
		wr(EPROM_CTL_IDX, 32'h0000_0021);
		@(negedge mclk);
		check("eprom voltage", {31'h0, epromProgramVoltageOn}, 32'h1);
		expectReg("read under voltage", ARRAY_DATA_IDX, 32'h0000_0000);
		wr(EPROM_CTL_IDX, 32'h0000_0000);
		expectReg("eprom verify", ARRAY_DATA_IDX, 32'h0000_00A5);
		// EEPROM write: latch, address/data, program, delay, clear
		wr(EEPROM_CTL_IDX, 32'h0000_0002);
		wr(ARRAY_ADDR_IDX, 32'h0000_0040);
		wr(ARRAY_DATA_IDX, 32'h0000_003C);
		wr(EEPROM_CTL_IDX, 32'h0000_0003);
		wr(ARRAY_DATA_IDX, 32'h0000_0099);
		@(negedge mclk);
		check("eeprom voltage", {31'h0, eepromProgramVoltageOn}, 32'h1);
		check("blocked write", {24'h0, nvWrData}, 32'h3C);
		repeat (100) @(posedge mclk);
		wr(EEPROM_CTL_IDX, 32'h0000_0000);
		@(negedge mclk);
		check("eeprom off", {31'h0, eepromProgramVoltageOn}, 32'h0);
		expectReg("eeprom verify", ARRAY_DATA_IDX, 32'h0000_003C);
		wr(EEPROM_CTL_IDX, 32'h0000_001F);
		@(negedge mclk);
		check("erase selects", {eepromErase, eepromRowSelect, eepromByteSelect}, 32'h7);
		wr(EEPROM_CTL_IDX, 32'h0000_0000);
		// Multi-byte: refused outside test mode, then bit 5 ignored
		wr(TEST_IDX, 32'h0000_0001);
		expectReg("mbe refused", TEST_IDX, 32'h0000_0000);
		testMode <= 1'b1;
		wr(TEST_IDX, 32'h0000_0001);
		wr(EPROM_CTL_IDX, 32'h0000_0020);
		wr(ARRAY_ADDR_IDX, 32'h0000_00FF);
		wr(ARRAY_DATA_IDX, 32'h0000_0077);
		@(negedge mclk);
		check("addr5 ignored", {15'h0, ignoreAddr5, nvAddr}, 32'h0001_00DF);
		wr(EPROM_CTL_IDX, 32'h0000_0021);
		wr(EPROM_CTL_IDX, 32'h0000_0000);
		testMode <= 1'b0;
		expectReg("mbe cleared", TEST_IDX, 32'h0000_0000);
		expectReg("twin byte", ARRAY_DATA_IDX, 32'h0000_0077);
		// Bootstrap: slow host, two bytes, two ticks each
		i_host_link_model.sendQueue.push_back(8'h5A);
		i_host_link_model.sendQueue.push_back(8'hC3);
		slowReady <= 1'b1;
		burnCycles = 0;
		wr(BOOT_DELAY_IDX, 32'h0000_0002);
		wr(BOOT_START_IDX, 32'h0000_0200);
		wr(BOOT_COUNT_IDX, 32'h0000_0002);
		for (int n = 0; n < 3000 && resetPulses == 0; n++) @(posedge mclk);
		repeat (5) @(posedge mclk);
		check("ready code seen", {31'h0, i_host_link_model.started}, 32'h1);
		check("echo count", i_host_link_model.echoes.size(), 32'h2);
		check("echoes", {i_host_link_model.echoes[0], i_host_link_model.echoes[1]}, 32'h5AC3);
		check("burned bytes", {i_host_link_model.mem[16'h0200], i_host_link_model.mem[16'h0201]}, 32'h5AC3);
		check("reset pulses", resetPulses, 32'h1);
		check("burn time", burnCycles >= 2 * TICK_CYCLES && burnCycles <= 4 * TICK_CYCLES + 2, 32'h1);
		results();
	end
endmodule
`default_nettype wire
